// ===== lps_pkg.sv
`default_nettype none
package lps_pkg;

   // clock and waveform timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned PWM_STEPS = 256;
   localparam int unsigned IND_PWM_HZ = 97_000;
   localparam int unsigned GRP_DIM_HZ = 190;
   localparam int unsigned BLINK_BASE_HZ = 24;
   localparam int unsigned IND_STEP_RAW = CLK_HZ / (PWM_STEPS * IND_PWM_HZ);
   localparam int unsigned IND_STEP_CYCLES =
      (IND_STEP_RAW < 1) ? 1 : IND_STEP_RAW;
   localparam int unsigned DIM_STEP_RAW = CLK_HZ / (PWM_STEPS * GRP_DIM_HZ);
   localparam int unsigned DIM_STEP_CYCLES =
      (DIM_STEP_RAW < 1) ? 1 : DIM_STEP_RAW;
   localparam int unsigned BLINK_STEP_RAW =
      CLK_HZ / (PWM_STEPS * BLINK_BASE_HZ);
   localparam int unsigned BLINK_STEP_CYCLES =
      (BLINK_STEP_RAW < 1) ? 1 : BLINK_STEP_RAW;
   localparam int unsigned PRESCALE_W = 16;

   // register byte offsets
   localparam int unsigned ADDR_W = 12;
   localparam logic [11:0] ADDR_OUT_CFG = 12'h000;
   localparam logic [11:0] ADDR_LED_STATE = 12'h004;
   localparam logic [11:0] ADDR_GRP_DUTY = 12'h008;
   localparam logic [11:0] ADDR_GRP_FREQ = 12'h00C;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam logic [11:0] ADDR_DUTY_BASE = 12'h040;
   localparam int unsigned DUTY_IDX_W = 4;
   localparam int unsigned MAX_CH = 16;

   // status field positions
   localparam int unsigned STATUS_PIN_LSB = 0;
   localparam int unsigned STATUS_OE_BIT = 16;

   // led state select codes
   localparam logic [1:0] LED_OFF = 2'h0;
   localparam logic [1:0] LED_ON = 2'h1;
   localparam logic [1:0] LED_IND = 2'h2;
   localparam logic [1:0] LED_IND_GRP = 2'h3;

   // disabled output state codes
   localparam logic [1:0] DIS_LOW = 2'h0;
   localparam logic [1:0] DIS_HIGH = 2'h1;
   localparam logic [1:0] DIS_FLOAT = 2'h2;

   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef struct packed {
      logic group_mode_select;
      logic [1:0] disabled_output_state;
      logic totem_pole_drive_select;
      logic output_polarity_invert;
   } lps_out_cfg_s;

   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic word;
   } lps_bus_req_s;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ,
      BUS_DATA
   } lps_bus_state_e;

   // values after reset
   localparam lps_out_cfg_s OUT_CFG_RESET = '{
      group_mode_select: 1'b0,
      disabled_output_state: DIS_LOW,
      totem_pole_drive_select: 1'b1,
      output_polarity_invert: 1'b0
   };
   localparam logic [31:0] LED_STATE_RESET = 32'h0000_0000;
   localparam logic [7:0] GRP_DUTY_RESET = 8'hFF;
   localparam logic [7:0] GRP_FREQ_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;

endpackage
`default_nettype wire

// ===== lps_duty_bank.sv
`timescale 1ns/100ps
`default_nettype none
module lps_duty_bank #(
   parameter int unsigned NUM_CH = 16,
   parameter int unsigned DATA_W = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wr_en_in,
   input wire logic [lps_pkg::DUTY_IDX_W-1:0] wr_idx_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic [lps_pkg::DUTY_IDX_W-1:0] rd_idx_in,
   output logic [DATA_W-1:0] rd_data_out,
   output logic [NUM_CH*DATA_W-1:0] words_out
);
   import lps_pkg::*;

   logic [DATA_W-1:0] mem [NUM_CH];

   if (NUM_CH < 1 || NUM_CH > MAX_CH)
   begin : g_bad_ch
      $error("duty bank supports 1 to 16 channels");
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            mem[i] <= DATA_W'(DUTY_RESET);
         end
      end
      else if (wr_en_in && (32'(wr_idx_in) < NUM_CH))
      begin
         mem[wr_idx_in] <= wr_data_in;
      end
   end

   // registered read port for the bus side
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_out <= '0;
      end
      else if (32'(rd_idx_in) < NUM_CH)
      begin
         rd_data_out <= mem[rd_idx_in];
      end
      else
      begin
         rd_data_out <= '0;
      end
   end

   // every channel's duty word is presented to the compare every cycle
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         words_out[i*DATA_W +: DATA_W] = mem[i];
      end
   end

endmodule
`default_nettype wire

// ===== lps_led_output_stage.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [R1] invert applies only while outputs enabled
// [R2] disabled outputs follow disabled state field
// [R3] open-drain never drives high; totem complementary
// [R4] off/on levels per invert and drive
// [R5] state 10 drives duty; invert flips
// [R6] state 11 gates duty with group
// [R7] per-channel 8-bit duty brightness waveform
// [R8] group dimming waveform from group duty
// [R9] blinking period set by frequency value
// [R10] only one group waveform at once
// [R11] host sets invert/drive for external drivers
// [R12] mode select one blinks, zero dims
// [R13] disabled codes: low, high/float, float
// [R14] active while phase below duty value
module lps_led_output_stage #(
   parameter int unsigned NUM_CH = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic output_enable_n_in,
   input wire logic [NUM_CH-1:0] led_output_pin_in,
   output logic [NUM_CH-1:0] led_output_pin_out,
   output logic [NUM_CH-1:0] led_output_pin_oe_out
);
   import lps_pkg::*;

   if (NUM_CH < 1 || NUM_CH > MAX_CH)
   begin : g_bad_ch
      $error("output stage supports 1 to 16 channels");
   end

   function automatic logic is_duty(input logic [11:0] addr);
      logic hit;
      hit = (addr[11:6] == ADDR_DUTY_BASE[11:6]) && (addr[1:0] == 2'h0);
      return hit && (32'(addr[5:2]) < NUM_CH);
   endfunction

   function automatic logic wave_on(input logic [7:0] phase,
                                    input logic [7:0] duty);
      return phase < duty;
   endfunction

   lps_bus_state_e bus_state;
   lps_bus_req_s req;
   lps_out_cfg_s out_cfg;
   logic [31:0] led_state_select;
   logic [7:0] group_duty_value;
   logic [7:0] group_freq_value;
   logic [7:0] duty_rd;
   logic [NUM_CH*8-1:0] channel_duty_value;
   logic accept;
   logic wr_cycle;
   logic [31:0] next_rdata;
   logic oe_n_meta;
   logic oe_n_sync;
   logic [NUM_CH-1:0] pin_meta;
   logic [NUM_CH-1:0] pin_sync;
   logic [PRESCALE_W-1:0] ind_pre;
   logic [7:0] ind_phase;
   logic [PRESCALE_W-1:0] grp_pre;
   logic [PRESCALE_W-1:0] grp_limit;
   logic [7:0] freq_cnt;
   logic [7:0] grp_phase;
   logic grp_on;
   logic [NUM_CH-1:0] next_pin;
   logic [NUM_CH-1:0] next_oe;

   assign accept = hsel_in && htrans_in[1] && hready_in;
   assign wr_cycle = (bus_state == BUS_WRITE) && req.word;

   // bus sequencing: writes one wait, reads two
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         bus_state <= BUS_IDLE;
         req <= '0;
         hreadyout_out <= 1'b1;
         hrdata_out <= 32'h0000_0000;
         hresp_out <= HRESP_OKAY;
      end
      else
      begin
         hresp_out <= HRESP_OKAY;
         unique case (bus_state)
            BUS_IDLE:
            begin
               if (accept)
               begin
                  req.addr <= haddr_in[11:0];
                  req.write <= hwrite_in;
                  req.word <= (hsize_in == HSIZE_WORD);
                  hreadyout_out <= 1'b0;
                  bus_state <= hwrite_in ? BUS_WRITE : BUS_READ;
               end
            end
            BUS_WRITE:
            begin
               hreadyout_out <= 1'b1;
               bus_state <= BUS_IDLE;
            end
            BUS_READ:
            begin
               bus_state <= BUS_DATA;
            end
            BUS_DATA:
            begin
               hrdata_out <= next_rdata;
               hreadyout_out <= 1'b1;
               bus_state <= BUS_IDLE;
            end
         endcase
      end
   end

   // read data; unmapped offsets read as zero
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (is_duty(req.addr))
      begin
         next_rdata = {24'h00_0000, duty_rd};
      end
      else
      begin
         unique case (req.addr)
            ADDR_OUT_CFG:
               next_rdata = 32'(out_cfg);
            ADDR_LED_STATE:
               next_rdata = led_state_select;
            ADDR_GRP_DUTY:
               next_rdata = {24'h00_0000, group_duty_value};
            ADDR_GRP_FREQ:
               next_rdata = {24'h00_0000, group_freq_value};
            ADDR_STATUS:
            begin
               next_rdata[STATUS_PIN_LSB +: 16] = 16'(pin_sync);
               next_rdata[STATUS_OE_BIT] = oe_n_sync;
            end
            default:
               next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // control registers, word writes only
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         out_cfg <= OUT_CFG_RESET;
         led_state_select <= LED_STATE_RESET;
         group_duty_value <= GRP_DUTY_RESET;
         group_freq_value <= GRP_FREQ_RESET;
      end
      else if (wr_cycle)
      begin
         unique case (req.addr)
            ADDR_OUT_CFG:
               out_cfg <= lps_out_cfg_s'(hwdata_in[4:0]);
            ADDR_LED_STATE:
               led_state_select <= hwdata_in;
            ADDR_GRP_DUTY:
               group_duty_value <= hwdata_in[7:0];
            ADDR_GRP_FREQ:
               group_freq_value <= hwdata_in[7:0];
            default:
            begin
            end
         endcase
      end
   end

   lps_duty_bank #(
      .NUM_CH(NUM_CH),
      .DATA_W(8)
   ) u_duty_bank (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(wr_cycle && is_duty(req.addr)),
      .wr_idx_in(req.addr[5:2]),
      .wr_data_in(hwdata_in[7:0]),
      .rd_idx_in(req.addr[5:2]),
      .rd_data_out(duty_rd),
      .words_out(channel_duty_value)
   );

   // output enable and pin readback come from outside the clock domain
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         oe_n_meta <= 1'b1;
         oe_n_sync <= 1'b1;
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         oe_n_meta <= output_enable_n_in;
         oe_n_sync <= oe_n_meta;
         pin_meta <= led_output_pin_in;
         pin_sync <= pin_meta;
      end
   end

   // [R7] individual brightness phase
   // clock too slow for full rate: one phase step per cycle at most
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         ind_pre <= '0;
         ind_phase <= 8'h00;
      end
      else if (ind_pre >= PRESCALE_W'(IND_STEP_CYCLES - 1))
      begin
         ind_pre <= '0;
         ind_phase <= ind_phase + 8'h01;
      end
      else
      begin
         ind_pre <= ind_pre + PRESCALE_W'(1);
      end
   end

   // [R12] mode select picks step length
   assign grp_limit = out_cfg.group_mode_select ?
      PRESCALE_W'(BLINK_STEP_CYCLES - 1) : PRESCALE_W'(DIM_STEP_CYCLES - 1);

   // [R8] [R9] [R10] one shared group phase for dim or blink
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         grp_pre <= '0;
         freq_cnt <= 8'h00;
         grp_phase <= 8'h00;
      end
      else if (grp_pre >= grp_limit)
      begin
         grp_pre <= '0;
         if (!out_cfg.group_mode_select)
         begin
            freq_cnt <= 8'h00;
            grp_phase <= grp_phase + 8'h01;
         end
         else if (freq_cnt >= group_freq_value)
         begin
            freq_cnt <= 8'h00;
            grp_phase <= grp_phase + 8'h01;
         end
         else
         begin
            freq_cnt <= freq_cnt + 8'h01;
         end
      end
      else
      begin
         grp_pre <= grp_pre + PRESCALE_W'(1);
      end
   end

   // [R14] group waveform active below duty
   assign grp_on = wave_on(grp_phase, group_duty_value);

   // per channel transistor selection
   always_comb
   begin
      logic lit;
      logic low_on;
      logic high_on;
      lit = 1'b0;
      low_on = 1'b0;
      high_on = 1'b0;
      next_pin = '0;
      next_oe = '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         unique case (led_state_select[2*i +: 2])
            LED_OFF:
               lit = 1'b0;
            LED_ON:
               lit = 1'b1;
            // [R5] [R14] individual duty waveform
            LED_IND:
               lit = wave_on(ind_phase, channel_duty_value[8*i +: 8]);
            // [R6] individual gated by group
            LED_IND_GRP:
               lit = wave_on(ind_phase, channel_duty_value[8*i +: 8]) &&
                     grp_on;
         endcase
         // [R1] [R4] lit sinks unless inverted
         low_on = lit ^ out_cfg.output_polarity_invert;
         // [R3] upper only with totem pole
         high_on = !low_on && out_cfg.totem_pole_drive_select;
         if (oe_n_sync)
         begin
            // [R2] [R13] disabled state overrides
            unique case (out_cfg.disabled_output_state)
               DIS_LOW:
               begin
                  low_on = 1'b1;
                  high_on = 1'b0;
               end
               DIS_HIGH:
               begin
                  low_on = 1'b0;
                  high_on = out_cfg.totem_pole_drive_select;
               end
               default:
               begin
                  low_on = 1'b0;
                  high_on = 1'b0;
               end
            endcase
         end
         next_pin[i] = high_on;
         next_oe[i] = high_on || low_on;
      end
   end

   // pins registered; released during reset
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         led_output_pin_out <= '0;
         led_output_pin_oe_out <= '0;
      end
      else
      begin
         led_output_pin_out <= next_pin;
         led_output_pin_oe_out <= next_oe;
      end
   end

endmodule
`default_nettype wire

// ===== lps_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lps_monitor #(
   parameter int unsigned NUM_CH = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic output_enable_n_in,
   input wire logic [NUM_CH-1:0] led_output_pin_out,
   input wire logic [NUM_CH-1:0] led_output_pin_oe_out
);
   import lps_pkg::*;
   lps_out_cfg_s cfg;
   logic [31:0] state;
   logic [7:0] grp;
   logic wr_pend;
   logic [11:0] wr_addr;
   logic oen_q;
   logic [2:0] quiet;
   logic [NUM_CH-1:0] known;
   logic [NUM_CH-1:0] exp_oe;
   logic [NUM_CH-1:0] exp_out;
   wire logic taken = hsel_in & htrans_in[1] & hready_in & hreadyout_out;
   wire logic wr_edge = wr_pend & ~hreadyout_out;
   // pins lag config and the enable sync, so judge only once settled
   wire logic settled = quiet == 3'h7 && oen_q == output_enable_n_in;
   wire logic dis_hi = cfg.disabled_output_state == DIS_HIGH
      && cfg.totem_pole_drive_select;
   wire logic dis_drv = cfg.disabled_output_state == DIS_LOW || dis_hi;
   wire logic [NUM_CH-1:0] sourcing = led_output_pin_out
      & led_output_pin_oe_out;

   always_ff @(posedge clk_in)
      if (!rst_n_in)
         wr_pend <= 1'b0;
      else if (taken)
      begin
         wr_pend <= hwrite_in && hsize_in == HSIZE_WORD;
         wr_addr <= haddr_in[11:0];
      end
      else if (hreadyout_out)
         wr_pend <= 1'b0;

   always_ff @(posedge clk_in)
      if (!rst_n_in)
      begin
         cfg <= OUT_CFG_RESET;
         state <= LED_STATE_RESET;
         grp <= GRP_DUTY_RESET;
      end
      else if (wr_edge && wr_addr == ADDR_OUT_CFG)
         cfg <= lps_out_cfg_s'(hwdata_in[4:0]);
      else if (wr_edge && wr_addr == ADDR_LED_STATE)
         state <= hwdata_in;
      else if (wr_edge && wr_addr == ADDR_GRP_DUTY)
         grp <= hwdata_in[7:0];

   always_ff @(posedge clk_in)
   begin
      oen_q <= output_enable_n_in;
      if (!rst_n_in || wr_edge || oen_q != output_enable_n_in)
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
   end

   always_comb
      for (int i = 0; i < NUM_CH; i++)
      begin
         known[i] = state[2*i+:2] != LED_IND
            && (state[2*i+:2] != LED_IND_GRP || grp == 8'h00);
         exp_oe[i] = ((state[2*i+:2] == LED_ON)
            ^ cfg.output_polarity_invert) | cfg.totem_pole_drive_select;
         exp_out[i] = !((state[2*i+:2] == LED_ON)
            ^ cfg.output_polarity_invert) & cfg.totem_pole_drive_select;
      end

   default clocking mon_clk @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_open_drain_only:
      assert property (settled && !cfg.totem_pole_drive_select
         |-> sourcing == '0)
      else $error("open-drain pin sourced high");
   a_totem_always_driven:
      assert property (settled && cfg.totem_pole_drive_select
         && !output_enable_n_in |-> &led_output_pin_oe_out)
      else $error("totem-pole pin left floating");
   a_disabled_level:
      assert property (settled && output_enable_n_in
         |-> led_output_pin_oe_out == {NUM_CH{dis_drv}}
         && sourcing == {NUM_CH{dis_hi}})
      else $error("disabled pins wrong level");
   a_static_state:
      assert property (settled && !output_enable_n_in
         |-> ((led_output_pin_oe_out ^ exp_oe) & known) == '0
         && ((led_output_pin_out ^ exp_out) & exp_oe & known) == '0)
      else $error("off or on pin wrong level");
   a_write_wait:
      assert property (taken && hwrite_in
         |=> !hreadyout_out ##1 hreadyout_out)
      else $error("write wait state wrong");
   a_read_wait:
      assert property (taken && !hwrite_in
         |=> !hreadyout_out [*2] ##1 hreadyout_out)
      else $error("read wait states wrong");
   a_resp_okay:
      assert property (hresp_out == HRESP_OKAY)
      else $error("bus response not okay");
   a_rdata_held:
      assert property ($past(hreadyout_out) && hreadyout_out
         |-> $stable(hrdata_out))
      else $error("read data changed while idle");
endmodule

bind lps_led_output_stage lps_monitor #(.NUM_CH(NUM_CH)) u_mon (
   .clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
   .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
   .hresp_out, .output_enable_n_in, .led_output_pin_out,
   .led_output_pin_oe_out
);
`default_nettype wire

// ===== lps_led_load.sv
`timescale 1ns/100ps
`default_nettype none
module lps_led_load #(
   parameter int unsigned NUM_CH = 16
) (
   input wire logic [NUM_CH-1:0] drive_in,
   input wire logic [NUM_CH-1:0] drive_oe_in,
   output logic [NUM_CH-1:0] level_out
);
   // released pins go high through the pull-up or led resistor
   assign level_out = (drive_in & drive_oe_in) | ~drive_oe_in;
endmodule
`default_nettype wire

// ===== lps_led_output_stage_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module lps_led_output_stage_tb_top;
   import lps_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0000_0000;
   logic oe_n = 1'b1;
   logic [31:0] hrdata;
   logic hrdy;
   logic hresp;
   logic [15:0] pin_out;
   logic [15:0] pin_oe;
   logic [15:0] pin_lvl;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   int cnt [4];

   lps_led_output_stage #(.NUM_CH(16)) dut (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .hsel_in(hsel),
      .haddr_in(haddr),
      .htrans_in(htrans),
      .hwrite_in(hwrite),
      .hsize_in(hsize),
      .hwdata_in(hwdata),
      .hready_in(hrdy),
      .hrdata_out(hrdata),
      .hreadyout_out(hrdy),
      .hresp_out(hresp),
      .output_enable_n_in(oe_n),
      .led_output_pin_in(pin_lvl),
      .led_output_pin_out(pin_out),
      .led_output_pin_oe_out(pin_oe)
   );
   lps_led_load #(.NUM_CH(16)) load (
      .drive_in(pin_out),
      .drive_oe_in(pin_oe),
      .level_out(pin_lvl)
   );

   initial
      forever #50 clk_in = ~clk_in;

   // longest path is one full group dimming period plus setup
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_in); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hrdy !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0000_0000, q);
   endtask

   task automatic count_sink(input int n);
      cnt = '{default: 0};
      repeat (n)
      begin
         @(posedge clk_in);
         for (int i = 0; i < 4; i++)
            cnt[i] += int'(pin_oe[i] & !pin_out[i]);
      end
   endtask

   task automatic t_regs();
      logic [31:0] q;
      rd(ADDR_OUT_CFG, q);
      chk("out cfg reset", 32'(OUT_CFG_RESET), q);
      rd(ADDR_GRP_DUTY, q);
      chk("group duty reset", 32'(GRP_DUTY_RESET), q);
      // narrow writes complete but must not store
      hsize <= 3'h0;
      wr(ADDR_GRP_DUTY, 32'h0000_0011);
      hsize <= HSIZE_WORD;
      rd(ADDR_GRP_DUTY, q);
      chk("narrow write kept", 32'(GRP_DUTY_RESET), q);
      chk("response", 32'(HRESP_OKAY), 32'(hresp));
      wr(ADDR_GRP_FREQ, 32'h0000_005A);
      rd(ADDR_GRP_FREQ, q);
      chk("group freq", 32'h0000_005A, q);
      wr(12'h020, 32'hFFFF_FFFF);
      rd(12'h020, q);
      chk("unmapped", 32'h0000_0000, q);
      wr(ADDR_DUTY_BASE + 12'h03C, 32'h1234_56A5);
      rd(ADDR_DUTY_BASE + 12'h03C, q);
      chk("duty 15", 32'h0000_00A5, q);
      $display("register test done");
   endtask

   task automatic t_disabled();
      logic [31:0] q;
      logic [1:0] code;
      logic tp;
      wr(ADDR_LED_STATE, 32'h5555_5555);
      for (int k = 0; k < 8; k++)
      begin
         code = 2'(k >> 1);
         tp = k[0];
         wr(ADDR_OUT_CFG, {27'h000_0000, 1'b0, code, tp, 1'b1});
         repeat (8) @(posedge clk_in);
         chk("disabled oe", 32'({16{code == DIS_LOW
            || (code == DIS_HIGH && tp)}}), 32'(pin_oe));
         chk("disabled out", 32'({16{code == DIS_HIGH && tp}}),
            32'(pin_out & pin_oe));
         if (code == DIS_FLOAT)
         begin
            rd(ADDR_STATUS, q);
            chk("status", 32'h0001_FFFF, q);
         end
      end
      $display("disabled test done");
   endtask

   task automatic t_static();
      logic low;
      logic [15:0] e_oe;
      logic [15:0] e_out;
      oe_n <= 1'b0;
      wr(ADDR_GRP_DUTY, 32'h0000_0000);
      wr(ADDR_LED_STATE, 32'h3434_3434);
      for (int k = 0; k < 4; k++)
      begin
         wr(ADDR_OUT_CFG, {30'h0000_0000, k[1], k[0]});
         repeat (8) @(posedge clk_in);
         for (int i = 0; i < 16; i++)
         begin
            low = ((i % 4) == 1) ^ k[0];
            e_oe[i] = low | k[1];
            e_out[i] = !low & k[1];
         end
         chk("static oe", 32'(e_oe), 32'(pin_oe));
         chk("static out", 32'(e_out), 32'(pin_out & pin_oe));
      end
      $display("static test done");
   endtask

   task automatic t_duty();
      logic [7:0] dv [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
      wr(ADDR_LED_STATE, 32'hAAAA_AAAA);
      for (int i = 0; i < 4; i++)
         wr(ADDR_DUTY_BASE + 12'(4 * i), 32'(dv[i]));
      for (int v = 0; v < 2; v++)
      begin
         wr(ADDR_OUT_CFG, {30'h0000_0000, 1'b1, v[0]});
         repeat (3) @(posedge clk_in);
         count_sink(256);
         for (int i = 0; i < 4; i++)
            chk("duty sink", v[0] ? 32'(256 - dv[i]) : 32'(dv[i]),
               32'(cnt[i]));
      end
      $display("duty test done");
   endtask

   task automatic t_group();
      wr(ADDR_LED_STATE, 32'h0000_0003);
      wr(ADDR_DUTY_BASE, 32'h0000_00FF);
      wr(ADDR_OUT_CFG, 32'h0000_0002);
      wr(ADDR_GRP_DUTY, 32'h0000_0080);
      count_sink(52480);
      chk("group dim", 32'h0000_0001,
         32'(cnt[0] inside {[26137:26138]}));
      wr(ADDR_OUT_CFG, 32'h0000_0012);
      wr(ADDR_GRP_DUTY, 32'h0000_0000);
      count_sink(256);
      chk("blink dark", 32'h0000_0000, 32'(cnt[0]));
      $display("group test done");
   endtask

   initial
   begin
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_regs();
      t_disabled();
      t_static();
      t_duty();
      t_group();
      close_out();
   end
endmodule
`default_nettype wire
